// ==== design/spimc_core.v ====
// Purpose: Byte-wide full-duplex four-wire serial port.
// Assumes: Control and status as plain ports, one clock.
// Notes:   Pins split into input, output and enable.
`timescale 1ns/1ps
`include "spimc_regs.vh"
module spimc_core #(
  parameter DIV_W = 16
) (
  input  wire             CLK_I,        // System clock, 20 MHz
  input  wire             RSTN_I,       // Synchronous reset, active low
  input  wire             CTL_WR_I,     // Control write strobe
  input  wire             CTL_EN_I,     // Port enable value
  input  wire             CTL_MASTER_I, // Master enable value
  input  wire             CTL_CLOCK_POLARITY_SELECT_I,   // Clock polarity value
  input  wire             CTL_CLOCK_PHASE_SELECT_I,   // Clock phase value
  input  wire             CTL_IRQEN_I,  // Interrupt enable value
  input  wire             STAT_RD_I,    // Status read strobe
  input  wire             TX_WR_I,      // Transmit shift write strobe
  input  wire [7:0]       TX_DATA_I,    // Transmit byte
  input  wire             DIV_LO_WR_I,  // Divisor low byte write
  input  wire             DIV_HI_WR_I,  // Divisor high byte write
  input  wire [7:0]       DIV_DATA_I,   // Divisor byte data
  input  wire             SCK_I,        // Serial clock pin in
  input  wire             SS_N_I,       // Slave select pin, active low
  input  wire             MOSI_I,       // MOSI pin in
  input  wire             MISO_I,       // MISO pin in
  output wire             SCK_O,        // Serial clock pin out
  output wire             SCK_OE_O,     // Serial clock drive enable
  output wire             MOSI_O,       // MOSI pin out
  output wire             MOSI_OE_O,    // MOSI drive enable
  output wire             MISO_O,       // MISO pin out
  output wire             MISO_OE_O,    // MISO drive enable
  output wire [7:0]       RX_DATA_O,    // Receive buffer
  output wire             EN_O,         // Port enable state
  output wire             MASTER_O,     // Master enable state
  output wire             CLOCK_POLARITY_SELECT_O,       // Polarity state
  output wire             CLOCK_PHASE_SELECT_O,       // Phase state
  output wire             IRQEN_O,      // Interrupt enable state
  output wire             MODE_FAULT_O, // Mode fault flag
  output wire             WR_COLL_O,    // Write collision flag
  output wire             DONE_O,       // Transfer done flag
  output wire             BUSY_O,       // Transfer in progress
  output wire             IRQ_O,        // Interrupt request, active high
  output wire [DIV_W-1:0] DIVISOR_O     // Divisor readback
);

  // ----------------------------------------------------------------
  // Input synchronisers and divider
  // ----------------------------------------------------------------
  wire [3:0] sync_q;
  wire       s_sck;
  wire       s_ss_n;
  wire       s_mosi;
  wire       s_miso;
  wire       tick;

  spimc_sync #(
    .W   (4),
    .RST (`SPIMC_SYNC_RST)
  ) u_sync (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .d_i    ({SCK_I, SS_N_I, MOSI_I, MISO_I}),
    .q_o    (sync_q)
  );

  assign s_sck  = sync_q[3];
  assign s_ss_n = sync_q[2];
  assign s_mosi = sync_q[1];
  assign s_miso = sync_q[0];

  spimc_brg #(
    .W (DIV_W)
  ) u_brg (
    .clk_i   (CLK_I),
    .rstn_i  (RSTN_I),
    .lo_wr_i (DIV_LO_WR_I),
    .hi_wr_i (DIV_HI_WR_I),
    .data_i  (DIV_DATA_I),
    .div_o   (DIVISOR_O),
    .tick_o  (tick)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg       en_r,      en_nxt;
  reg       master_r,  master_nxt;
  reg       clock_polarity_select_r,    clock_polarity_select_nxt;
  reg       clock_phase_select_r,    clock_phase_select_nxt;
  reg       irqen_r,   irqen_nxt;
  reg       busy_r,    busy_nxt;
  reg [3:0] half_r,    half_nxt;
  reg [3:0] bits_r,    bits_nxt;
  reg [7:0] sh_r,      sh_nxt;
  reg [7:0] rxbuf_r,   rxbuf_nxt;
  reg       out_r,     out_nxt;
  reg       sck_r,     sck_nxt;
  reg       mode_fault_flag_r,    mode_fault_flag_nxt;
  reg       write_collision_flag_r,    write_collision_flag_nxt;
  reg       done_r,    done_nxt;
  reg       irq_r,     irq_nxt;
  reg       sck_oe_r,  sck_oe_nxt;
  reg       mosi_oe_r, mosi_oe_nxt;
  reg       miso_oe_r, miso_oe_nxt;
  // Edge history of the synchronised pins
  reg       sck_prev_r;
  reg       ss_prev_r;

  // ----------------------------------------------------------------
  // Edge decode
  // ----------------------------------------------------------------
  // Edges judged on synchronised pins, two to three clocks late
  wire sck_edge  = s_sck ^ sck_prev_r;
  wire lead_edge = sck_edge & (s_sck ^ clock_polarity_select_r);
  wire trail_edge = sck_edge & ~(s_sck ^ clock_polarity_select_r);
  wire selected  = ~s_ss_n;
  wire ss_fall   = ss_prev_r & s_ss_n == 1'b0;
  // Phase 0 samples on leading edge, phase 1 on trailing
  wire s_sample  = selected & (clock_phase_select_r ? trail_edge : lead_edge);
  wire s_drive   = selected & (clock_phase_select_r ? lead_edge : trail_edge);
  // Master: phase picks which half period samples
  wire m_sample  = tick & (half_r[0] == clock_phase_select_r);
  wire m_drive   = tick & (half_r[0] != clock_phase_select_r);
  wire s_start1  = clock_phase_select_r & ~busy_r & selected & lead_edge;
  wire s_start0  = ~clock_phase_select_r & ~busy_r & ss_fall;

  // ----------------------------------------------------------------
  // Transfer qualifiers
  // ----------------------------------------------------------------
  wire m_mode    = en_r & master_r;
  wire m_fault   = m_mode & ~s_ss_n;
  wire m_last    = tick & (half_r == `SPIMC_HALF_LAST);
  wire s_first   = s_start0 | s_start1;
  wire s_left    = bits_r != `SPIMC_BIT_COUNT;
  // New phase 1 frame must not see the old full count
  wire s_active  = (busy_r & s_left) | s_start1;
  wire s_last    = s_sample & (bits_r == `SPIMC_BIT_LAST);
  wire tx_coll   = TX_WR_I & (busy_r | s_first);
  wire tx_load   = TX_WR_I & ~tx_coll;
  wire m_launch  = tx_load & m_mode & s_ss_n;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always @* begin
    en_nxt      = en_r;
    master_nxt  = master_r;
    clock_polarity_select_nxt    = clock_polarity_select_r;
    clock_phase_select_nxt    = clock_phase_select_r;
    irqen_nxt   = irqen_r;
    busy_nxt    = busy_r;
    half_nxt    = half_r;
    bits_nxt    = bits_r;
    sh_nxt      = sh_r;
    rxbuf_nxt   = rxbuf_r;
    out_nxt     = out_r;
    sck_nxt     = sck_r;
    mode_fault_flag_nxt    = mode_fault_flag_r;
    write_collision_flag_nxt    = write_collision_flag_r;
    done_nxt    = done_r;

    // Control fields taken whole on one strobe
    if (CTL_WR_I) begin
      en_nxt     = CTL_EN_I;
      master_nxt = CTL_MASTER_I;
      clock_polarity_select_nxt   = CTL_CLOCK_POLARITY_SELECT_I;
      clock_phase_select_nxt   = CTL_CLOCK_PHASE_SELECT_I;
      irqen_nxt  = CTL_IRQEN_I;
    end

    // Clear first so that a same-cycle set wins
    if (STAT_RD_I) begin
      mode_fault_flag_nxt = 1'b0;
      write_collision_flag_nxt = 1'b0;
      done_nxt = 1'b0;
    end

    if (!en_r) begin
      busy_nxt = 1'b0;
      sck_nxt  = clock_polarity_select_r;
    end else if (master_r) begin
      // Select low as master: abort, clear enable and master
      if (m_fault) begin
        mode_fault_flag_nxt   = 1'b1;
        en_nxt     = 1'b0;
        master_nxt = 1'b0;
        busy_nxt   = 1'b0;
        sck_nxt    = clock_polarity_select_r;
      end else if (busy_r) begin
        // Each divider tick is one serial half period
        if (tick) begin
          sck_nxt  = ~sck_r;
          half_nxt = half_r + 4'h1;
          if (m_drive) begin
            out_nxt = sh_r[7];
          end
          if (m_sample) begin
            sh_nxt = {sh_r[6:0], s_miso};
          end
          if (m_last) begin
            busy_nxt  = 1'b0;
            rxbuf_nxt = sh_nxt;
            done_nxt  = 1'b1;
          end
        end
      end else begin
        sck_nxt = clock_polarity_select_r;
      end
    end else begin
      sck_nxt = clock_polarity_select_r;
      if (s_first) begin
        busy_nxt = 1'b1;
        bits_nxt = 4'h0;
      end
      // Phase 0 refreshes bit 7 at select fall
      if (s_start0) begin
        out_nxt = sh_r[7];
      end
      // Phase 0 frame ends only when select rises
      if (!clock_phase_select_r && busy_r && !selected) begin
        busy_nxt = 1'b0;
      end
      if (s_active) begin
        if (s_drive) begin
          out_nxt = sh_r[7];
        end
        if (s_sample) begin
          sh_nxt   = {sh_r[6:0], s_mosi};
          bits_nxt = bits_r + 4'h1;
          if (s_last) begin
            rxbuf_nxt = sh_nxt;
            done_nxt  = 1'b1;
            if (clock_phase_select_r) begin
              busy_nxt = 1'b0;
            end
          end
        end
      end
    end

    // Write dropped whole while a frame runs or starts
    if (tx_coll) begin
      write_collision_flag_nxt = 1'b1;
    end
    if (tx_load) begin
      sh_nxt = TX_DATA_I;
      if (!clock_phase_select_r) begin
        out_nxt = TX_DATA_I[7];
      end
      if (m_launch) begin
        busy_nxt = 1'b1;
        half_nxt = 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin enables and interrupt
  // ----------------------------------------------------------------
  always @* begin
    // Enables follow next state so pins and control agree
    sck_oe_nxt  = en_nxt & master_nxt;
    mosi_oe_nxt = en_nxt & master_nxt;
    miso_oe_nxt = en_nxt & ~master_nxt & selected;
    irq_nxt     = irqen_nxt & (mode_fault_flag_nxt | write_collision_flag_nxt | done_nxt);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Every state bit clears on the synchronous reset except clock_phase_select_r and ss_prev_r, which set
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      en_r       <= `SPIMC_EN_RST;
      master_r   <= `SPIMC_MASTER_RST;
      clock_polarity_select_r     <= `SPIMC_CLOCK_POLARITY_SELECT_RST;
      clock_phase_select_r     <= `SPIMC_CLOCK_PHASE_SELECT_RST;
      irqen_r    <= `SPIMC_IRQEN_RST;
      busy_r     <= 1'b0;
      half_r     <= 4'h0;
      bits_r     <= 4'h0;
      sh_r       <= 8'h00;
      rxbuf_r    <= 8'h00;
      out_r      <= 1'b0;
      sck_r      <= `SPIMC_CLOCK_POLARITY_SELECT_RST;
      mode_fault_flag_r     <= 1'b0;
      write_collision_flag_r     <= 1'b0;
      done_r     <= 1'b0;
      irq_r      <= 1'b0;
      sck_oe_r   <= 1'b0;
      mosi_oe_r  <= 1'b0;
      miso_oe_r  <= 1'b0;
      sck_prev_r <= 1'b0;
      ss_prev_r  <= 1'b1;
    end else begin
      en_r       <= en_nxt;
      master_r   <= master_nxt;
      clock_polarity_select_r     <= clock_polarity_select_nxt;
      clock_phase_select_r     <= clock_phase_select_nxt;
      irqen_r    <= irqen_nxt;
      busy_r     <= busy_nxt;
      half_r     <= half_nxt;
      bits_r     <= bits_nxt;
      sh_r       <= sh_nxt;
      rxbuf_r    <= rxbuf_nxt;
      out_r      <= out_nxt;
      sck_r      <= sck_nxt;
      mode_fault_flag_r     <= mode_fault_flag_nxt;
      write_collision_flag_r     <= write_collision_flag_nxt;
      done_r     <= done_nxt;
      irq_r      <= irq_nxt;
      sck_oe_r   <= sck_oe_nxt;
      mosi_oe_r  <= mosi_oe_nxt;
      miso_oe_r  <= miso_oe_nxt;
      sck_prev_r <= s_sck;
      ss_prev_r  <= s_ss_n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SCK_O        = sck_r;
  assign SCK_OE_O     = sck_oe_r;
  // MOSI and MISO share one data flop; enables pick the pin
  assign MOSI_O       = out_r;
  assign MOSI_OE_O    = mosi_oe_r;
  assign MISO_O       = out_r;
  assign MISO_OE_O    = miso_oe_r;
  assign RX_DATA_O    = rxbuf_r;
  assign EN_O         = en_r;
  assign MASTER_O     = master_r;
  assign CLOCK_POLARITY_SELECT_O       = clock_polarity_select_r;
  assign CLOCK_PHASE_SELECT_O       = clock_phase_select_r;
  assign IRQEN_O      = irqen_r;
  assign MODE_FAULT_O = mode_fault_flag_r;
  assign WR_COLL_O    = write_collision_flag_r;
  assign DONE_O       = done_r;
  assign BUSY_O       = busy_r;
  assign IRQ_O        = irq_r;

endmodule

// ==== design/spimc_regs.vh ====
// Purpose: Constants for the serial port core.
// Assumes: 20 MHz system clock, one clock domain.
// Notes:   Included by the core and baud-rate divider design files.
`ifndef SPIMC_REGS_VH
`define SPIMC_REGS_VH

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPIMC_DIV_RST     16'h0002
`define SPIMC_EN_RST      1'b0
`define SPIMC_MASTER_RST  1'b0
`define SPIMC_CLOCK_POLARITY_SELECT_RST    1'b0
`define SPIMC_CLOCK_PHASE_SELECT_RST    1'b1
`define SPIMC_IRQEN_RST   1'b0
`define SPIMC_SYNC_RST    4'h4

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define SPIMC_HALF_LAST   4'hf
`define SPIMC_BIT_LAST    4'h7
`define SPIMC_BIT_COUNT   4'h8
`define SPIMC_DIV_ONE     16'h0001

`endif

// ==== design/spimc_sync.v ====
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs asynchronous to CLK_I.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module spimc_sync #(
  parameter         W   = 4,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         clk_i,   // System clock
  input  wire         rstn_i,  // Synchronous reset, active low
  input  wire [W-1:0] d_i,     // Asynchronous inputs
  output reg  [W-1:0] q_o      // Synchronised outputs
);

  reg [W-1:0] meta_r;

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_r <= RST;
      q_o    <= RST;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

// ==== design/spimc_brg.v ====
// Purpose: Baud-rate divider with end-of-count pulse.
// Assumes: Divisor written a byte at a time.
// Notes:   A byte write reloads and restarts the count.
`timescale 1ns/1ps
`include "spimc_regs.vh"
module spimc_brg #(
  parameter W = 16
) (
  input  wire         clk_i,    // System clock
  input  wire         rstn_i,   // Synchronous reset, active low
  input  wire         lo_wr_i,  // Write low divisor byte
  input  wire         hi_wr_i,  // Write high divisor byte
  input  wire [7:0]   data_i,   // Divisor byte data
  output reg  [W-1:0] div_o,    // Divisor readback
  output reg          tick_o    // End-of-count pulse
);

  reg  [W-1:0] cnt_r;
  wire [W-1:0] div_nxt;

  assign div_nxt = lo_wr_i ? {div_o[W-1:8], data_i} :
                   hi_wr_i ? {data_i, div_o[7:0]} : div_o;

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      div_o  <= `SPIMC_DIV_RST;
      cnt_r  <= `SPIMC_DIV_RST;
      tick_o <= 1'b0;
    end else begin
      div_o  <= div_nxt;
      tick_o <= 1'b0;
      if (lo_wr_i || hi_wr_i) begin
        cnt_r <= div_nxt;
      end else if (cnt_r <= `SPIMC_DIV_ONE) begin
        cnt_r  <= div_o;
        tick_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r - `SPIMC_DIV_ONE;
      end
    end
  end

endmodule

// ==== verif/spimc_core_sva.sv ====
// Purpose: Concurrent checks on the serial port core pins.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every spimc_core instance.
`timescale 1ns/1ps
module spimc_core_sva (
  input wire CLK_I,        // Clock
  input wire RSTN_I,       // Reset, active low
  input wire TX_WR_I,      // Transmit write
  input wire STAT_RD_I,    // Status read
  input wire SS_N_I,       // Select, active low
  input wire SCK_O,        // Serial clock out
  input wire SCK_OE_O,     // Clock enable
  input wire MOSI_OE_O,    // MOSI enable
  input wire MISO_OE_O,    // MISO enable
  input wire EN_O,         // Port enable
  input wire MASTER_O,     // Master enable
  input wire CLOCK_POLARITY_SELECT_O,       // Polarity
  input wire IRQEN_O,      // Interrupt enable
  input wire MODE_FAULT_O, // Mode fault
  input wire WR_COLL_O,    // Collision
  input wire DONE_O,       // Done
  input wire BUSY_O,       // Busy
  input wire IRQ_O         // Interrupt
);
  reg       sck_q;
  reg [4:0] tog_r;

  // ----------------------------------------
  // Clock edge count of one master transfer
  // ----------------------------------------
  always @(posedge CLK_I) begin
    sck_q <= SCK_O;
    if (!RSTN_I || (TX_WR_I && !BUSY_O)) begin
      tog_r <= 5'h00;
    end else if (SCK_O != sck_q) begin
      tog_r <= tog_r + 5'h01;
    end
  end

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence ss_low_s;
    !SS_N_I [*3];
  endsequence
  sequence fault_s;
    MODE_FAULT_O && !EN_O && !MASTER_O;
  endsequence

  oe_off_a: assert property (!EN_O && !$past(EN_O) |-> !MOSI_OE_O && !MISO_OE_O && !SCK_OE_O)
    else $error("pin driven while port disabled");
  miso_rel_a: assert property (SS_N_I [*5] |-> !MISO_OE_O)
    else $error("MISO driven while unselected");
  drive_own_a: assert property (SCK_OE_O || MOSI_OE_O |-> EN_O && MASTER_O)
    else $error("clock or MOSI driven outside master mode");
  slave_out_a: assert property (MISO_OE_O |-> EN_O && !MASTER_O)
    else $error("MISO driven outside slave mode");
  sck_idle_a: assert property (SCK_OE_O && !BUSY_O && !$past(BUSY_O) && $stable(CLOCK_POLARITY_SELECT_O) |-> SCK_O == CLOCK_POLARITY_SELECT_O)
    else $error("clock not at idle level");
  fault_a: assert property ((EN_O && MASTER_O) ##0 ss_low_s |-> ##[0:3] fault_s)
    else $error("select low in master mode not faulted");
  irq_a: assert property (IRQ_O == (IRQEN_O && (MODE_FAULT_O || WR_COLL_O || DONE_O)))
    else $error("interrupt does not match flags");
  coll_a: assert property (BUSY_O && TX_WR_I |=> WR_COLL_O)
    else $error("busy write without collision");
  rd_clr_a: assert property (STAT_RD_I && !TX_WR_I |=> !WR_COLL_O)
    else $error("collision not cleared by read");
  eight_clk_a: assert property ($rose(DONE_O) && MASTER_O |-> tog_r + (SCK_O ^ sck_q) == 5'h10)
    else $error("master transfer not sixteen clock edges");
  done_idle_a: assert property ($rose(DONE_O) && MASTER_O |-> !BUSY_O)
    else $error("done while still busy");
endmodule

bind spimc_core spimc_core_sva u_spimc_core_sva (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .TX_WR_I(TX_WR_I), .STAT_RD_I(STAT_RD_I), .SS_N_I(SS_N_I),
  .SCK_O(SCK_O), .SCK_OE_O(SCK_OE_O), .MOSI_OE_O(MOSI_OE_O), .MISO_OE_O(MISO_OE_O), .EN_O(EN_O),
  .MASTER_O(MASTER_O), .CLOCK_POLARITY_SELECT_O(CLOCK_POLARITY_SELECT_O), .IRQEN_O(IRQEN_O), .MODE_FAULT_O(MODE_FAULT_O),
  .WR_COLL_O(WR_COLL_O), .DONE_O(DONE_O), .BUSY_O(BUSY_O), .IRQ_O(IRQ_O)
);

// ==== verif/spimc_peer.sv ====
// Purpose: Behavioural serial slave on the master-side lines.
// Assumes: Select and mode given by the bench.
// Notes:   Released line shows the inverse of its last bit.
`timescale 1ns/1ps
module spimc_peer (
  input  wire       sck_i,   // Serial clock
  input  wire       sel_n_i, // Select, active low
  input  wire       mosi_i,  // Data in
  input  wire       clock_polarity_select_i,  // Polarity
  input  wire       clock_phase_select_i,  // Phase
  input  wire [7:0] tx_i,    // Byte to return
  output reg        miso_o,  // Data out
  output reg  [7:0] rx_o     // Byte received
);
  reg [7:0] sh;

  initial begin
    miso_o = 1'b0;
    rx_o = 8'h00;
    sh = 8'h00;
  end

  // First bit ready as soon as selected
  always @(negedge sel_n_i) begin
    sh = tx_i;
    miso_o = tx_i[7];
  end

  always @(posedge sel_n_i) miso_o = ~miso_o;

  always @(sck_i) begin
    if (!sel_n_i && ((sck_i != clock_polarity_select_i) ^ clock_phase_select_i)) begin
      rx_o = {rx_o[6:0], mosi_i};
    end else if (!sel_n_i && clock_phase_select_i) begin
      miso_o = sh[7];
      sh = {sh[6:0], 1'b0};
    end else if (!sel_n_i) begin
      sh = {sh[6:0], 1'b0};
      miso_o = sh[7];
    end
  end
endmodule

// ==== verif/spimc_core_tb.sv ====
// Purpose: Self-checking bench for the serial port core.
// Assumes: Peer slave on the master lines, bench as master.
// Notes:   Received bytes checked by a monitor from a queue.
`timescale 1ns/1ps
module spimc_core_tb;
  localparam [4:0] s_ctl = 5'h10;
  localparam [4:0] s_rd  = 5'h08;
  localparam [4:0] s_tx  = 5'h04;
  localparam [4:0] s_lo  = 5'h02;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg  [4:0] stb = 5'h00;
  reg  [7:0] d8 = 8'h00;
  reg        ss_n = 1'b1;
  reg        sck_m = 1'b0;
  reg        mosi_m = 1'b0;
  reg        sel_n = 1'b1;
  reg  [1:0] mode = 2'h0;
  reg  [7:0] pr_tx = 8'h00;
  reg  [7:0] b, mb, got;
  reg        done_q = 1'b0;
  reg  [7:0] rxq[$];
  integer    seed = 22790;
  integer    errors = 0;
  integer    num_checks = 0;
  integer    m, i;
  wire       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_miso;
  wire       en, master, clock_phase_select, fault, coll, done, irq;
  wire [7:0] p_rx, rx_data;
  wire [15:0] divisor;
  wire       sck_w  = sck_oe ? sck_o : sck_m;
  wire       mosi_w = mosi_oe ? mosi_o : mosi_m;
  wire       miso_w = miso_oe ? miso_o : p_miso;

  spimc_core u_spimc_core (
    .CLK_I(clk), .RSTN_I(rstn), .CTL_WR_I(stb[4]), .CTL_EN_I(d8[4]), .CTL_MASTER_I(d8[3]),
    .CTL_CLOCK_POLARITY_SELECT_I(d8[2]), .CTL_CLOCK_PHASE_SELECT_I(d8[1]), .CTL_IRQEN_I(d8[0]), .STAT_RD_I(stb[3]), .TX_WR_I(stb[2]),
    .TX_DATA_I(d8), .DIV_LO_WR_I(stb[1]), .DIV_HI_WR_I(stb[0]), .DIV_DATA_I(d8), .SCK_I(sck_w),
    .SS_N_I(ss_n), .MOSI_I(mosi_w), .MISO_I(miso_w), .SCK_O(sck_o), .SCK_OE_O(sck_oe), .MOSI_O(mosi_o),
    .MOSI_OE_O(mosi_oe), .MISO_O(miso_o), .MISO_OE_O(miso_oe), .RX_DATA_O(rx_data), .EN_O(en),
    .MASTER_O(master), .CLOCK_POLARITY_SELECT_O(), .CLOCK_PHASE_SELECT_O(clock_phase_select), .IRQEN_O(), .MODE_FAULT_O(fault), .WR_COLL_O(coll),
    .DONE_O(done), .BUSY_O(), .IRQ_O(irq), .DIVISOR_O(divisor)
  );

  spimc_peer u_spimc_peer (
    .sck_i(sck_w), .sel_n_i(sel_n), .mosi_i(mosi_w), .clock_polarity_select_i(mode[0]), .clock_phase_select_i(mode[1]),
    .tx_i(pr_tx), .miso_o(p_miso), .rx_o(p_rx)
  );

  always #25 clk = ~clk;

  // ----------------------------------------
  // Drivers and comparisons
  // ----------------------------------------
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask

  task pulse(input [4:0] s, input [7:0] d);
    begin
      @(posedge clk);
      stb <= s;
      d8 <= d;
      @(posedge clk);
      stb <= 5'h00;
    end
  endtask

  task chk(input [15:0] got_v, input [15:0] exp_v);
    begin
      num_checks = num_checks + 1;
      if (got_v !== exp_v) begin
        errors = errors + 1;
        $display("ERROR %0t: got %h expected %h", $time, got_v, exp_v);
      end
    end
  endtask

  task summarize;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  task wait_done;
    integer k;
    begin
      k = 0;
      while (done !== 1'b1 && k < 2000) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k == 2000) begin
        errors = errors + 1;
        $display("ERROR %0t: transfer never completed", $time);
        summarize;
      end
    end
  endtask

  // Takes the oldest expected byte as each transfer completes
  always @(posedge clk) begin
    done_q <= done;
    if (done === 1'b1 && done_q !== 1'b1) chk(rx_data, rxq.size() ? rxq.pop_front() : 8'hxx);
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({en, master, clock_phase_select, sck_oe, mosi_oe, miso_oe}, 16'h0008);
    chk(divisor, 16'h0002);
    pulse(s_lo, 8'h03);
    pulse(5'h01, 8'h00);
    tick(1);
    chk(divisor, 16'h0003);
    $display("test reset and divisor: done");
    for (m = 0; m < 4; m = m + 1) begin
      mode = m;
      pulse(s_ctl, {5'b00000});
      pulse(s_ctl, {3'b011, m[0], m[1], 1'b1});
      tick(3);
      chk(sck_o, m[0]);
      b = $random(seed);
      mb = $random(seed);
      rxq.push_back(mb);
      @(posedge clk);
      pr_tx <= mb;
      sel_n <= 1'b0;
      pulse(s_tx, b);
      if (m == 3) begin
        tick(4);
        pulse(s_tx, ~b);
        tick(1);
        chk(coll, 1'b1);
      end
      wait_done;
      tick(1);
      chk(p_rx, b);
      @(posedge clk);
      sel_n <= 1'b1;
      pulse(s_rd, 8'h00);
      tick(1);
      chk({done, coll, irq}, 16'h0000);
      $display("test master mode %0d: done", m);
    end
    pulse(s_ctl, 8'h1b);
    @(posedge clk);
    ss_n <= 1'b0;
    tick(6);
    chk({fault, en, master, irq}, 16'h0009);
    @(posedge clk);
    ss_n <= 1'b1;
    pulse(s_rd, 8'h00);
    tick(1);
    chk({fault, irq}, 16'h0000);
    $display("test mode fault: done");
    for (m = 0; m < 2; m = m + 1) begin
      pulse(s_ctl, {4'b0100, m[0], 1'b0});
      b = $random(seed);
      mb = $random(seed);
      rxq.push_back(mb);
      pulse(s_tx, b);
      tick(4);
      chk({miso_oe, sck_oe}, 16'h0000);
      @(posedge clk);
      ss_n <= 1'b0;
      tick(4);
      chk(miso_oe, 1'b1);
      for (i = 7; i >= 0; i = i - 1) begin
        @(posedge clk);
        mosi_m <= mb[i];
        tick(8);
        @(posedge clk);
        sck_m <= 1'b1;
        if (!m[0]) got[i] = miso_w;
        tick(8);
        @(posedge clk);
        sck_m <= 1'b0;
        if (m[0]) got[i] = miso_w;
      end
      wait_done;
      chk(got, b);
      @(posedge clk);
      ss_n <= 1'b1;
      tick(5);
      chk(miso_oe, 1'b0);
      pulse(s_rd, 8'h00);
      $display("test slave phase %0d: done", m);
    end
    summarize;
  end
endmodule
